// *** spi_daisy_pkg.sv ***
// Constants shared by the daisy-chain SPI slave front end
package spi_daisy_pkg;
    localparam int FRAME_BITS      = 16;              // Own frame length
    localparam int CHAIN_STEP_BITS = 8;               // Extra bits come in bytes
    localparam int CNT_BITS        = 12;              // SCLK edge counter width
    localparam logic [1:0] PFX_WRITE = 2'h2;          // Write command prefix
    localparam logic [1:0] PFX_READ  = 2'h1;          // Read command prefix
    localparam logic [15:0] RESET_REPLY = 16'h0000;   // Shift register value after reset
    localparam int LEAD_NS         = 200;             // Master lead and lag time
    localparam int CLK_MHZ         = 200;             // System clock rate
    localparam int LEAD_CYC        = (LEAD_NS * CLK_MHZ) / 1000;
endpackage

// *** spi_sync2.sv ***
// Two-flop synchroniser for the SPI pins
`timescale 1ns/10ps
`default_nettype none
module spi_sync2 #(
    parameter int WIDTH = 3                 // Number of synchronised bits
) (
    input  wire logic             mclk,     // System clock
    input  wire logic             rst_n,    // Async reset, active low
    input  wire logic             clkEn,    // Clock enable
    input  wire logic [WIDTH-1:0] pinIn,    // Raw pins
    output var  logic [WIDTH-1:0] syncOut   // Synchronised pins
);
    // First and second stages
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t state_r;                   // Registered state
    sync_state_t state_nxt;                 // Next state

    // Shift pins through the two stages
    always_comb begin
        state_nxt = state_r;
        if (clkEn) begin
            state_nxt.stage1 = pinIn;
            state_nxt.stage2 = state_r.stage1;
        end
    end

    // Register the stages; CS idles high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '{default: '1};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign syncOut = state_r.stage2;
endmodule // spi_sync2
`default_nettype wire

// *** spi_slave_daisy_chain.sv ***
// SPI slave front end with frame length check and daisy-chain support
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Select falling edge starts access, clears count
// - Sample input on falling, drive on rising
// - Accept only 16 plus multiple of 8
// - Select high: ignore pins, output released
// - Select falling loads reply into shifter
// - Before first clock output is error OR input
// - Sleep at select fall keeps output released, no transfer
// - Valid frame passes shifter to addressed register
// - Input frame MSB first, control then data
// - Reply shifted out MSB first on rising
// - One shifter passes frames down the chain
// - Answer comes in the next transfer
// - Prefix 10 writes, 01 reads, else error
module spi_slave_daisy_chain
    import spi_daisy_pkg::*;
#(
    parameter int WIDTH = FRAME_BITS        // Shift register width
) (
    input  wire logic             mclk,              // System clock 200 MHz
    input  wire logic             rst_n,             // Async reset, active low
    input  wire logic             clkEn,             // Freezes all state when low
    input  wire logic             master_select_line,// Chip select pin, active low
    input  wire logic             sclkPin,           // Serial clock pin
    input  wire logic             master_out_line,   // Serial input pin
    input  wire logic             sleepMode,         // Device sleep, same domain
    input  wire logic [WIDTH-1:0] replyData,         // Reply for next transfer
    output var  logic             master_in_line,    // Serial output value
    output var  logic             soOe,              // Serial output drive enable
    output var  logic [WIDTH-1:0] cmdData,           // Received frame
    output var  logic             cmdWrite,          // Write command pulse
    output var  logic             cmdRead,           // Read command pulse
    output var  logic             syntaxErr,         // Bad prefix pulse
    output var  logic             transfer_error_flag // Sticky length error
);
    // Transfer phases, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,                    // Deselected or asleep
        ST_FIRST = 3'h2,                    // Selected, before first clock
        ST_SHIFT = 3'h4                     // Clocking data
    } phase_t;

    // Whole module state
    typedef struct packed {
        phase_t           phase;
        logic             csPrev;
        logic             sclkPrev;
        logic [WIDTH-1:0] shiftReg;
        logic [CNT_BITS-1:0] edgeCnt;
        logic             soBit;
        logic             soOe;
        logic [WIDTH-1:0] cmdData;
        logic             cmdWrite;
        logic             cmdRead;
        logic             syntaxErr;
        logic             terFlag;
        logic             terShown;
    } slave_state_t;

    slave_state_t state_r;                  // Registered state
    slave_state_t state_nxt;                // Next state
    logic [2:0]   pinSync;                  // Synchronised select, clock, data
    logic         csS;                      // Select after sync
    logic         sclkS;                    // Clock after sync
    logic         siS;                      // Data after sync
    logic         csFall;                   // Select falling edge
    logic         csRise;                   // Select rising edge
    logic         sclkFall;                 // Clock falling edge
    logic         sclkRise;                 // Clock rising edge
    logic         lenOk;                    // Frame length valid

    // Pins cross into the mclk domain
    spi_sync2 #(.WIDTH(3)) u_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .pinIn   ({master_select_line, sclkPin, master_out_line}),
        .syncOut (pinSync)
    );

    assign csS      = pinSync[2];
    assign sclkS    = pinSync[1];
    assign siS      = pinSync[0];
    assign csFall   = state_r.csPrev & ~csS;
    assign csRise   = ~state_r.csPrev & csS;
    assign sclkFall = state_r.sclkPrev & ~sclkS;
    assign sclkRise = ~state_r.sclkPrev & sclkS;
    // length check: 16, 24, 32 ...
    assign lenOk    = (state_r.edgeCnt >= CNT_BITS'(FRAME_BITS)) &&
                      (state_r.edgeCnt[2:0] == 3'h0);

    // Next-state logic for the whole transfer
    always_comb begin
        state_nxt          = state_r;
        state_nxt.csPrev   = csS;
        state_nxt.sclkPrev = sclkS;
        state_nxt.cmdWrite = 1'b0;
        state_nxt.cmdRead  = 1'b0;
        state_nxt.syntaxErr = 1'b0;
        case (state_r.phase)
            ST_IDLE: begin
                state_nxt.soOe = 1'b0;
                if (csFall && !sleepMode) begin
                    state_nxt.edgeCnt  = '0;
                    state_nxt.shiftReg = replyData;
                    state_nxt.terShown = state_r.terFlag;
                    state_nxt.soBit    = state_r.terFlag | siS;
                    state_nxt.soOe     = 1'b1;
                    state_nxt.phase    = ST_FIRST;
                end
            end
            ST_FIRST, ST_SHIFT: begin
                // follow input until first rising clock
                if (state_r.phase == ST_FIRST) begin
                    state_nxt.soBit = state_r.terFlag | siS;
                end
                if (sclkRise) begin
                    state_nxt.soBit = state_r.shiftReg[WIDTH-1];
                    state_nxt.phase = ST_SHIFT;
                end
                if (sclkFall) begin
                    state_nxt.shiftReg = {state_r.shiftReg[WIDTH-2:0], siS};
                    if (state_r.edgeCnt != '1) begin
                        state_nxt.edgeCnt = state_r.edgeCnt + 1'b1;
                    end
                end
                if (csRise) begin
                    state_nxt.soOe  = 1'b0;
                    state_nxt.phase = ST_IDLE;
                    if (lenOk) begin
                        if (state_r.terShown) begin
                            state_nxt.terFlag = 1'b0;
                        end
                        state_nxt.cmdData = state_r.shiftReg;
                        case (state_r.shiftReg[WIDTH-1 -: 2])
                            PFX_WRITE: state_nxt.cmdWrite  = 1'b1;
                            PFX_READ:  state_nxt.cmdRead   = 1'b1;
                            default:   state_nxt.syntaxErr = 1'b1;
                        endcase
                    end else begin
                        state_nxt.terFlag = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt.phase = ST_IDLE;
                state_nxt.soOe  = 1'b0;
            end
        endcase
    end

    // State register with clock enable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r          <= '0;
            state_r.phase    <= ST_IDLE;
            state_r.csPrev   <= 1'b1;
            state_r.shiftReg <= WIDTH'(RESET_REPLY);
        end else if (clkEn) begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from flops
    assign master_in_line      = state_r.soBit;
    assign soOe                = state_r.soOe;
    assign cmdData             = state_r.cmdData;
    assign cmdWrite            = state_r.cmdWrite;
    assign cmdRead             = state_r.cmdRead;
    assign syntaxErr           = state_r.syntaxErr;
    assign transfer_error_flag = state_r.terFlag;

    // Checks
    a_idle_released: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_r.phase == ST_IDLE && csS && $past(csS)) |-> !soOe)
        else $error("output driven while deselected");
    a_sleep_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
        (clkEn && state_r.phase == ST_IDLE && csFall && sleepMode) |=> !soOe)
        else $error("output driven in sleep");
    a_bad_len_err: assert property (@(posedge mclk) disable iff (!rst_n)
        (clkEn && state_r.phase != ST_IDLE && csRise && !lenOk)
        |=> transfer_error_flag && !cmdWrite && !cmdRead)
        else $error("bad length not flagged");
    a_good_len_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
        (clkEn && state_r.phase != ST_IDLE && csRise && lenOk)
        |=> (cmdWrite || cmdRead || syntaxErr) && cmdData == $past(state_r.shiftReg))
        else $error("valid frame not passed on");
    a_first_or: assert property (@(posedge mclk) disable iff (!rst_n)
        (clkEn && state_r.phase == ST_IDLE && csFall && !sleepMode)
        |=> soOe && master_in_line == ($past(state_r.terFlag) | $past(siS)))
        else $error("first bit not error OR input");
    a_load_reply: assert property (@(posedge mclk) disable iff (!rst_n)
        (clkEn && state_r.phase == ST_IDLE && csFall && !sleepMode)
        |=> state_r.shiftReg == $past(replyData) && state_r.edgeCnt == 0)
        else $error("reply not loaded");
    a_msb_out: assert property (@(posedge mclk) disable iff (!rst_n)
        (clkEn && state_r.phase != ST_IDLE && sclkRise && !csRise)
        |=> master_in_line == $past(state_r.shiftReg[WIDTH-1]))
        else $error("wrong bit shifted out");
    a_sample_in: assert property (@(posedge mclk) disable iff (!rst_n)
        (clkEn && state_r.phase != ST_IDLE && sclkFall && !csRise)
        |=> state_r.shiftReg[0] == $past(siS))
        else $error("input not sampled");
    c_good_write: cover property (@(posedge mclk) cmdWrite);
    c_good_read: cover property (@(posedge mclk) cmdRead);
    c_len_error: cover property (@(posedge mclk) $rose(transfer_error_flag));
    c_err_clear: cover property (@(posedge mclk) $fell(transfer_error_flag));
endmodule // spi_slave_daisy_chain
`default_nettype wire

// *** spi_master_model.sv ***
// Behavioural SPI master that drives the slave pins
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
    input  wire logic mclk,   // Pacing clock
    input  wire logic soPin,  // Slave serial output
    input  wire logic soOe,   // Slave output enable
    output var  logic selN,   // Chip select, active low
    output var  logic sclk,   // Serial clock, 80 ns period
    output var  logic mosi    // Serial data, pulled down when idle
);
    // Idle: deselected, clock low, data at pull-down level
    initial begin
        selN = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    // Wait n clocks, then move pins just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // One frame of n bits; head is enable and output before the first clock
    task automatic xfer(input int n, input logic [31:0] d,
                        output logic [1:0] head, output logic [31:0] so);
        so = '0;
        mosi = d[n-1];
        selN = 1'b0;
        tick(40);
        head = {soOe, soPin};
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            tick(4);
            mosi = d[i];
            tick(4);
            so = {so[30:0], soPin};
            sclk = 1'b0;
            tick(8);
        end
        tick(32);
        selN = 1'b1;
        mosi = 1'b0;
    endtask
    // Clock and data activity while deselected
    task automatic noise();
        // clock stays low across the select rise
        tick(8);
        repeat (4) begin
            mosi = ~mosi;
            sclk = 1'b1;
            tick(8);
            sclk = 1'b0;
            tick(8);
        end
    endtask
endmodule // spi_master_model
`default_nettype wire

// *** tb.sv ***
// Randomised self-checking bench for the daisy-chain SPI slave
`timescale 1ns/10ps
`default_nettype none
module tb;
    import spi_daisy_pkg::*;
    localparam int LIMIT = 60000;                     // Cycle ceiling
    localparam int LENS[8] = '{16, 24, 32, 8, 17, 23, 16, 31}; // Frame lengths
    logic        mclk = 1'b0;                         // System clock
    logic        rst_n = 1'b0;                        // Reset, active low
    logic        sleepMode = 1'b0;                    // Sleep request
    logic        clkEn = 1'b1;                        // Clock enable, low freezes slave
    logic [15:0] replyData = 16'h0000;                // Reply for next frame
    logic        selN, sclk, mosi, soPin, soOe;       // Pins
    logic        cmdWrite, cmdRead, syntaxErr, errFlag; // Results
    logic [15:0] cmdData;                             // Received frame
    logic [31:0] rng = 32'h50;                        // Xorshift state
    int          err_count = 0;                       // Mismatches
    int          checked = 0;                         // Comparisons
    int          cyc = 0;                             // Cycle count
    int          nW = 0, nR = 0, nS = 0;              // Pulse counts
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    spi_slave_daisy_chain u_spi_slave_daisy_chain (.mclk(mclk), .rst_n(rst_n),
        .clkEn(clkEn), .master_select_line(selN), .sclkPin(sclk),
        .master_out_line(mosi), .sleepMode(sleepMode), .replyData(replyData),
        .master_in_line(soPin), .soOe(soOe), .cmdData(cmdData), .cmdWrite(cmdWrite),
        .cmdRead(cmdRead), .syntaxErr(syntaxErr), .transfer_error_flag(errFlag));
    spi_master_model u_spi_master_model (.mclk(mclk), .soPin(soPin), .soOe(soOe),
        .selN(selN), .sclk(sclk), .mosi(mosi));
    // Count pulses and cut a hang short
    always @(posedge mclk) begin
        cyc++;
        nW += int'(cmdWrite === 1'b1);
        nR += int'(cmdRead === 1'b1);
        nS += int'(syntaxErr === 1'b1);
        if (cyc == LIMIT) begin
            err_count++;
            tally_and_finish();
        end
    end
    // Next pseudo-random word
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // Reply bits first, then the earliest input bits
    function automatic logic [31:0] soExp(int n, logic [31:0] d, logic [15:0] r);
        logic [31:0] v;
        v = '0;
        for (int k = 0; k < n; k++)
            v = {v[30:0], (k < 16) ? r[15-k] : d[n-1-(k-16)]};
        return v;
    endfunction
    // Compare and count
    task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Print counts and verdict, then stop
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        logic [31:0] d, so, expP;
        logic [1:0]  head;
        logic        expErr, valid, live;
        int          n, w0, r0, s0;
        expErr = 1'b0;
        repeat (12) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge mclk);
        for (int t = 0; t < 40; t++) begin
            #1;
            n = LENS[t % 8];
            d = xs();
            // All four prefixes reach valid-length frames
            d[15:14] = t[1:0] ^ t[4:3];
            replyData = 16'(xs() >> 16);
            // Slot 6 alternates between sleep and a frozen clock enable
            sleepMode = (t % 16 == 6);
            clkEn = (t % 16 != 14);
            live = !sleepMode && clkEn;
            w0 = nW;
            r0 = nR;
            s0 = nS;
            u_spi_master_model.xfer(n, d, head, so);
            if (t % 5 == 3) u_spi_master_model.noise();
            repeat (12) @(posedge mclk);
            #1;
            valid = live && n >= FRAME_BITS && (n - FRAME_BITS) % CHAIN_STEP_BITS == 0;
            cmp("oe_head", 32'(live), 32'(head[1]));
            if (live) begin
                cmp("so_head", 32'(expErr | d[n-1]), 32'(head[0]));
                cmp("so_bits", soExp(n, d, replyData), so);
                expErr = !valid;
            end
            if (valid) cmp("cmd_data", 32'(d[15:0]), 32'(cmdData));
            expP = !valid ? 0 : (d[15:14] == PFX_WRITE) ? 32'h10000 :
                   (d[15:14] == PFX_READ) ? 32'h100 : 32'h1;
            cmp("pulses", expP, ((nW - w0) << 16) | ((nR - r0) << 8) | (nS - s0));
            cmp("err_flag", 32'(expErr), 32'(errFlag));
            cmp("oe_idle", 32'h0, 32'(soOe));
            // Mid-run reset clears the error flag and the held frame
            if (t == 20) begin
                rst_n = 1'b0;
                repeat (2) @(posedge mclk);
                #1 rst_n = 1'b1;
                expErr = 1'b0;
                repeat (4) @(posedge mclk);
                #1;
                cmp("err_reset", 32'h0, 32'(errFlag));
                cmp("cmd_reset", 32'h0, 32'(cmdData));
            end
            repeat (40) @(posedge mclk);
        end
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
